// [core/nibble_cpu_pkg.sv]
package nibble_cpu_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int NIB_W = 4;
  localparam int PC_W = 12;
  localparam int DADDR_W = 10;
  localparam int STACK_DEPTH = 8;

  // ****************************************************************
  // Opcodes (first byte, upper bits compared after masking)
  // ****************************************************************
  localparam logic [7:0] OP_XM = 8'hA0;
  localparam logic [7:0] OP_XI = 8'hFE;
  localparam logic [7:0] OP_XD = 8'hFF;
  localparam logic [7:0] OP_ROM_TABLE_READ = 8'h63;
  localparam logic [7:0] OP_LDZ = 8'h80;
  localparam logic [7:0] OP_LHI = 8'h40;
  localparam logic [7:0] OP_XA = 8'hE0;
  localparam logic [7:0] OP_SFB = 8'h50;
  localparam logic [7:0] OP_RFB = 8'h10;
  localparam logic [7:0] OP_JMP = 8'h68;
  localparam logic [7:0] OP_BANK = 8'hFD;
  localparam logic [7:0] OP_PAGE_JUMP_INDEXED = 8'hFA;
  localparam logic [7:0] OP_CZP = 8'hB0;
  localparam logic [7:0] OP_CAL = 8'hA8;
  localparam logic [7:0] OP_RT = 8'h62;
  localparam logic [7:0] OP_RTI = 8'h22;
  localparam logic [7:0] OP_BA = 8'h70;
  localparam logic [7:0] OP_BNA = 8'h30;
  localparam logic [7:0] OP_BM = 8'h74;
  localparam logic [7:0] OP_BNM = 8'h34;
  localparam logic [7:0] OP_BP = 8'h78;
  localparam logic [7:0] OP_BNP = 8'h38;
  localparam logic [7:0] OP_BF = 8'hD0;
  localparam logic [7:0] OP_BNF = 8'h90;
  localparam logic [7:0] OP_SPB = 8'h04;
  localparam logic [7:0] OP_RPB = 8'h24;
  localparam logic [7:0] OP_CTL = 8'h2C;
  localparam logic [7:0] OP_LI = 8'hC0;
  localparam logic [7:0] OP_CLA = 8'hC0;
  localparam logic [7:0] OP_CI = 8'h24;
  localparam logic [7:0] OP_NOP = 8'h00;

  // ****************************************************************
  // Flag area, control selector range, reset options
  // ****************************************************************
  localparam logic [9:0] FLAG_BASE = 10'h0F0;
  localparam logic [9:0] FLAG_STEP = 10'h100;
  localparam logic [3:0] CTL_SEL_MAX = 4'h8;
  localparam logic [4:0] DIV_FULL = 5'h00;
  localparam logic [4:0] DIV_SLOW = 5'h1F;
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;

  typedef enum logic [2:0] {ST_FETCH, ST_EXEC2, ST_BYTE2, ST_TABLE,
    ST_PORT2} state_e;

endpackage

// [core/nibble_cpu_core.sv]
`timescale 1ns/1ns
module nibble_cpu_core #(
  parameter int WDOG_LIMIT = 16384
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Mask options
  input wire logic div_slow_opt_in,
  input wire logic portc_high_opt_in,
  input wire logic portd_high_opt_in,
  input wire logic wdog_fit_in,
  // Program ROM
  output logic [nibble_cpu_pkg::PC_W-1:0] rom_addr_out,
  input wire logic [7:0] rom_data_in,
  // Data RAM
  output logic [nibble_cpu_pkg::DADDR_W-1:0] ram_addr_out,
  output logic [3:0] ram_wdata_out,
  output logic ram_we_out,
  input wire logic [3:0] ram_rdata_in,
  // Ports
  input wire logic [3:0] port_in,
  output logic [3:0] port_sel_out,
  output logic [3:0] portc_out,
  output logic [3:0] portd_out,
  output logic [3:0] port_wdata_out,
  output logic port_we_out,
  // Control and watchdog
  output logic [7:0] ctl_out,
  output logic global_irq_enable_out,
  output logic [4:0] div_ratio_out,
  input wire logic wdog_clear_in,
  output logic wdog_irq_out,
  // State
  output logic [3:0] main_operand_reg_out,
  output logic carry_flag_out,
  output logic zero_flag_out
);
  import nibble_cpu_pkg::*;

  initial begin
    if (WDOG_LIMIT < 2 || WDOG_LIMIT > 32768) begin
      $error("WDOG_LIMIT out of range");
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  state_e st_r, st_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [7:0] op_r, op_nxt;
  logic [3:0] ac_r, ac_nxt, e_r, e_nxt, dph_r, dph_nxt, dpl_r, dpl_nxt;
  logic cf_r, cf_nxt, zf_r, zf_nxt, csf_r, zsf_r;
  logic bank_r, bank_nxt, li_r, li_nxt, nop_r, nop_nxt;
  logic [3:0] wr_r [4];
  logic [3:0] wr_nxt [4];
  logic [PC_W-1:0] stk_r [STACK_DEPTH];
  logic [2:0] sp_r, sp_nxt;
  logic push, pop;
  logic [PC_W-1:0] push_val;
  logic [3:0] pc_out_r, pc_out_nxt, pd_out_r, pd_out_nxt;
  logic [7:0] ctl_r, ctl_nxt;
  logic gie_r, gie_nxt;
  logic [4:0] div_r, div_nxt;
  logic [14:0] wd_cnt_r;
  logic wd_irq_r;
  logic [3:0] wdat;
  logic we, pwe;

  // Flag bit n lives at nibble FLAG_BASE + 3 + (n/4) * FLAG_STEP, bit n mod 4.
  function automatic logic [9:0] flag_addr(input logic [3:0] n);
    flag_addr = FLAG_BASE + 10'h003
      + 10'(({8'h00, n[3:2]}) * FLAG_STEP);
  endfunction

  function automatic logic [3:0] bitmask(input logic [1:0] t);
    bitmask = 4'h1 << t;
  endfunction

  // ****************************************************************
  // Execute
  // ****************************************************************
  always_comb begin
    st_nxt = ST_FETCH; pc_nxt = pc_r; op_nxt = op_r;
    ac_nxt = ac_r; e_nxt = e_r; dph_nxt = dph_r; dpl_nxt = dpl_r;
    cf_nxt = cf_r; zf_nxt = zf_r; bank_nxt = bank_r;
    li_nxt = li_r; nop_nxt = nop_r;
    wr_nxt = wr_r; push = 1'b0; pop = 1'b0; push_val = '0;
    pc_out_nxt = pc_out_r; pd_out_nxt = pd_out_r;
    ctl_nxt = ctl_r; gie_nxt = gie_r; div_nxt = div_r;
    ram_addr_out = {dph_r[1:0], dph_r, dpl_r};
    rom_addr_out = pc_r;
    wdat = ac_r; we = 1'b0; pwe = 1'b0;
    unique case (st_r)
      ST_FETCH: begin
        op_nxt = rom_data_in;
        pc_nxt = PC_W'(pc_r + 12'h001);
        // The bank prefix must survive the jump's fetch to reach byte two.
        bank_nxt = bank_r && (rom_data_in[7:3] == OP_JMP[7:3]);
        li_nxt = 1'b0;
        if (nop_r && (rom_data_in[7:4] == OP_LI[7:4])) begin
          li_nxt = li_r;
        end else if (rom_data_in == OP_CLA) begin
          ac_nxt = 4'h0; zf_nxt = 1'b1;
          nop_nxt = li_r;
        end else if (rom_data_in[7:4] == OP_LI[7:4]) begin
          ac_nxt = rom_data_in[3:0]; li_nxt = 1'b1;
        end else if (rom_data_in[7:3] == OP_XM[7:3]) begin
          st_nxt = ST_EXEC2;
        end else if (rom_data_in == OP_XI || rom_data_in == OP_XD) begin
          st_nxt = ST_EXEC2;
        end else if (rom_data_in == OP_ROM_TABLE_READ) begin
          st_nxt = ST_TABLE;
        end else if (rom_data_in[7:4] == OP_LDZ[7:4]) begin
          dph_nxt = 4'h0; dpl_nxt = rom_data_in[3:0];
        end else if (rom_data_in[7:4] == OP_LHI[7:4]) begin
          dph_nxt = rom_data_in[3:0];
        end else if (rom_data_in[7:4] == OP_XA[7:4]
            && rom_data_in[0] == 1'b0 && rom_data_in[3] == 1'b0) begin
          ac_nxt = wr_r[rom_data_in[2:1]];
          wr_nxt[rom_data_in[2:1]] = ac_r;
        end else if (rom_data_in[7:4] == OP_SFB[7:4]
            || rom_data_in[7:4] == OP_RFB[7:4]) begin
          st_nxt = ST_EXEC2;
          ram_addr_out = flag_addr(rom_data_in[3:0]);
        end else if (rom_data_in == OP_BANK) begin
          bank_nxt = 1'b1;
        end else if (rom_data_in == OP_PAGE_JUMP_INDEXED) begin
          pc_nxt = {pc_r[11:8], e_r, ac_r};
        end else if (rom_data_in[7:4] == OP_CZP[7:4]) begin
          push = 1'b1; push_val = PC_W'(pc_r + 12'h001);
          pc_nxt = {6'h00, rom_data_in[3:0], 2'b00};
        end else if (rom_data_in == OP_RT || rom_data_in == OP_RTI) begin
          pop = 1'b1; pc_nxt = stk_r[sp_r - 3'd1];
          if (rom_data_in == OP_RTI) begin
            cf_nxt = csf_r; zf_nxt = zsf_r;
          end
        end else if (rom_data_in[7:2] == OP_SPB[7:2]
            || rom_data_in[7:2] == OP_RPB[7:2]) begin
          st_nxt = ST_PORT2;
        end else if (rom_data_in == OP_NOP) begin
          st_nxt = ST_FETCH;
        end else begin
          st_nxt = ST_BYTE2;
        end
      end
      ST_EXEC2: begin
        if (op_r[7:4] == OP_SFB[7:4] || op_r[7:4] == OP_RFB[7:4]) begin
          ram_addr_out = flag_addr(op_r[3:0]);
          we = 1'b1;
          if (op_r[6]) begin
            wdat = ram_rdata_in | bitmask(op_r[1:0]);
          end else begin
            wdat = ram_rdata_in & ~bitmask(op_r[1:0]);
            zf_nxt = (wdat == 4'h0);
          end
        end else begin
          we = 1'b1; ac_nxt = ram_rdata_in;
          if (op_r == OP_XI) begin
            dpl_nxt = dpl_r + 4'h1; zf_nxt = (dpl_nxt == 4'h0);
          end else if (op_r == OP_XD) begin
            dpl_nxt = dpl_r - 4'h1; zf_nxt = (dpl_nxt == 4'h0);
          end else if (op_r[2:0] != 3'b000) begin
            dph_nxt = dph_r | {1'b0, op_r[2:0]};
            zf_nxt = (dph_r == {1'b0, op_r[2:0]});
          end else begin
            zf_nxt = (dph_r == 4'h0);
          end
        end
      end
      ST_TABLE: begin
        rom_addr_out = {pc_r[11:8], e_r, ac_r};
        e_nxt = rom_data_in[7:4];
        ac_nxt = rom_data_in[3:0];
      end
      ST_PORT2: begin
        pwe = 1'b1;
        wdat = op_r[5] ? port_in & ~bitmask(op_r[1:0])
          : port_in | bitmask(op_r[1:0]);
        e_nxt = port_in;
        if (dpl_r == 4'hC) pc_out_nxt = wdat;
        if (dpl_r == 4'hD) pd_out_nxt = wdat;
      end
      ST_BYTE2: begin
        pc_nxt = PC_W'(pc_r + 12'h001);
        if (op_r[7:3] == OP_JMP[7:3]) begin
          pc_nxt = {pc_r[11] ^ bank_r, op_r[2:0], rom_data_in};
        end else if (op_r[7:3] == OP_CAL[7:3]) begin
          push = 1'b1; push_val = PC_W'(pc_r + 12'h001);
          pc_nxt = {1'b0, op_r[2:0], rom_data_in};
        end else if (op_r[7:2] == OP_CI[7:2]) begin
          cf_nxt = ({op_r[1:0], rom_data_in[7:6]} <= ac_r);
          zf_nxt = ({op_r[1:0], rom_data_in[7:6]} == ac_r);
        end else if (op_r == OP_CTL && rom_data_in[3:0] <= CTL_SEL_MAX) begin
          if (rom_data_in[3:0] == CTL_SEL_MAX) begin
            gie_nxt = ~rom_data_in[4];
          end else begin
            ctl_nxt[rom_data_in[2:0]] = ~rom_data_in[4];
            if (rom_data_in[2:0] == 3'd0) begin
              div_nxt = rom_data_in[4] ? DIV_SLOW : DIV_FULL;
            end
          end
        end else if (op_r[7:5] == OP_BF[7:5] || op_r[7:5] == OP_BNF[7:5]) begin
          ram_addr_out = flag_addr(op_r[3:0]);
          if (((ram_rdata_in & bitmask(op_r[1:0])) != 4'h0) == op_r[6])
            pc_nxt = {pc_r[11:8], rom_data_in};
        end else if (op_r[5:4] == 2'b11 && op_r[3:2] != 2'b11) begin
          unique case (op_r[3:2])
            2'b00: wdat = ac_r;
            2'b01: wdat = ram_rdata_in;
            default: wdat = port_in;
          endcase
          if (wdat[op_r[1:0]] == op_r[6])
            pc_nxt = {pc_r[11:8], rom_data_in};
          wdat = ac_r;
        end
      end
      default: st_nxt = ST_FETCH;
    endcase
  end

  // ****************************************************************
  // Sequential state
  // ****************************************************************
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= ST_FETCH; pc_r <= PC_RESET; op_r <= 8'h00;
      ac_r <= 4'h0; e_r <= 4'h0; dph_r <= 4'h0; dpl_r <= 4'h0;
      cf_r <= 1'b0; zf_r <= 1'b0; csf_r <= 1'b0; zsf_r <= 1'b0;
      bank_r <= 1'b0; li_r <= 1'b0; nop_r <= 1'b0; sp_r <= 3'd0;
      ctl_r <= 8'h00; gie_r <= 1'b0;
      for (int i = 0; i < 4; i++) wr_r[i] <= 4'h0;
      for (int i = 0; i < STACK_DEPTH; i++) stk_r[i] <= '0;
    end else begin
      st_r <= st_nxt; pc_r <= pc_nxt; op_r <= op_nxt;
      ac_r <= ac_nxt; e_r <= e_nxt; dph_r <= dph_nxt; dpl_r <= dpl_nxt;
      cf_r <= cf_nxt; zf_r <= zf_nxt;
      bank_r <= bank_nxt; li_r <= li_nxt; nop_r <= nop_nxt;
      wr_r <= wr_nxt; ctl_r <= ctl_nxt; gie_r <= gie_nxt;
      if (push) begin
        stk_r[sp_r] <= push_val; sp_r <= sp_r + 3'd1;
        csf_r <= cf_r; zsf_r <= zf_r;
      end else if (pop) begin
        sp_r <= sp_r - 3'd1;
      end
    end
  end

  // Divider and port-level mask options are ports, so they are caught at the first clock
  // after release rather than inside the asynchronous reset branch.
  logic init_r;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      init_r <= 1'b1; div_r <= DIV_FULL;
      pc_out_r <= 4'h0; pd_out_r <= 4'h0;
    end else if (init_r) begin
      init_r <= 1'b0;
      div_r <= div_slow_opt_in ? DIV_SLOW : DIV_FULL;
      pc_out_r <= {4{portc_high_opt_in}};
      pd_out_r <= {4{portd_high_opt_in}};
    end else begin
      div_r <= div_nxt; pc_out_r <= pc_out_nxt; pd_out_r <= pd_out_nxt;
    end
  end

  // Watchdog: request stays until firmware clears; a timeout in the same
  // cycle as the clear wins so no event is lost.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wd_cnt_r <= '0; wd_irq_r <= 1'b0;
    end else if (wdog_fit_in) begin
      if (wd_cnt_r == 15'(WDOG_LIMIT - 1)) begin
        wd_cnt_r <= '0; wd_irq_r <= 1'b1;
      end else begin
        wd_cnt_r <= wdog_clear_in ? '0 : wd_cnt_r + 15'd1;
        if (wdog_clear_in) wd_irq_r <= 1'b0;
      end
    end
  end

  assign ram_wdata_out = wdat;
  assign ram_we_out = we;
  assign port_sel_out = dpl_r;
  assign port_wdata_out = wdat;
  assign port_we_out = pwe;
  assign portc_out = pc_out_r;
  assign portd_out = pd_out_r;
  assign ctl_out = ctl_r;
  assign global_irq_enable_out = gie_r;
  assign div_ratio_out = div_r;
  assign wdog_irq_out = wd_irq_r;
  assign main_operand_reg_out = ac_r;
  assign carry_flag_out = cf_r;
  assign zero_flag_out = zf_r;

  property p_page_jump_indexed;
    @(posedge clock_in) disable iff (!nrst_in)
    (st_r == ST_FETCH && rom_data_in == OP_PAGE_JUMP_INDEXED && !nop_r)
      |=> pc_r[7:0] == $past({e_r, ac_r});
  endproperty
  a_page_jump_indexed: assert property (p_page_jump_indexed) else $error("page jump wrong");

  property p_xi;
    @(posedge clock_in) disable iff (!nrst_in)
    (st_r == ST_EXEC2 && op_r == OP_XI)
      |=> dpl_r == $past(dpl_r) + 4'h1 && zf_r == (dpl_r == 4'h0);
  endproperty
  a_xi: assert property (p_xi) else $error("swap-inc wrong");

  property p_ldz;
    @(posedge clock_in) disable iff (!nrst_in)
    (st_r == ST_FETCH && rom_data_in[7:4] == OP_LDZ[7:4] && !nop_r)
      |=> dph_r == 4'h0 && st_r == ST_FETCH;
  endproperty
  a_ldz: assert property (p_ldz) else $error("pointer load wrong");

  property p_two_cycle;
    @(posedge clock_in) disable iff (!nrst_in)
    (st_r == ST_FETCH && rom_data_in == OP_XD) |=> st_r == ST_EXEC2
      ##1 st_r == ST_FETCH;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("swap-dec timing");

  property p_wd;
    @(posedge clock_in) disable iff (!nrst_in)
    $rose(wd_irq_r) |-> wdog_fit_in && $past(wd_cnt_r) != 15'd0;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog raised wrongly");

  property p_czp;
    @(posedge clock_in) disable iff (!nrst_in)
    (st_r == ST_FETCH && rom_data_in[7:4] == OP_CZP[7:4] && !nop_r)
      |=> pc_r[11:6] == 6'h00 && pc_r[1:0] == 2'b00;
  endproperty
  a_czp: assert property (p_czp) else $error("zero-page call wrong");

  property p_rti;
    @(posedge clock_in) disable iff (!nrst_in)
    (st_r == ST_FETCH && rom_data_in == OP_RTI && !nop_r)
      |=> cf_r == $past(csf_r) && zf_r == $past(zsf_r);
  endproperty
  a_rti: assert property (p_rti) else $error("flags not restored");

  property p_port;
    @(posedge clock_in) disable iff (!nrst_in)
    st_r == ST_PORT2 |-> port_we_out ##1 st_r == ST_FETCH;
  endproperty
  a_port: assert property (p_port) else $error("port bit timing");

endmodule

// [sim/nibble_mem_model.sv]
`timescale 1ns/1ns
// ****************************************************************
// Program ROM, data RAM and port model
// ****************************************************************
// Contents are preset by the bench before reset is released.
// The port answer is the inverted select except for ports C and D, so a wrong select shows up.
module nibble_mem_model (
  // Clock
  input wire logic clock_in,
  // Program ROM
  input wire logic [nibble_cpu_pkg::PC_W-1:0] rom_addr_in,
  output logic [7:0] rom_data_out,
  // Data RAM
  input wire logic [nibble_cpu_pkg::DADDR_W-1:0] ram_addr_in,
  input wire logic [3:0] ram_wdata_in,
  input wire logic ram_we_in,
  output logic [3:0] ram_rdata_out,
  // Ports
  input wire logic [3:0] port_sel_in,
  input wire logic [3:0] portc_in,
  input wire logic [3:0] portd_in,
  output logic [3:0] port_data_out
);
  import nibble_cpu_pkg::*;

  logic [7:0] rom [0:4095];
  logic [3:0] ram [0:1023];

  assign rom_data_out = rom[rom_addr_in];
  assign ram_rdata_out = ram[ram_addr_in];
  // Ports C and D read back their output level; others answer ~select.
  assign port_data_out = (port_sel_in == 4'hC) ? portc_in
    : (port_sel_in == 4'hD) ? portd_in : ~port_sel_in;

  // Flag nibbles live in this array like any other data.
  always @(posedge clock_in) begin
    if (ram_we_in) begin
      ram[ram_addr_in] <= ram_wdata_in;
    end
  end
endmodule

// [sim/tb_nibble_cpu_instruction_execution.sv]
`timescale 1ns/1ns
`define CHECK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module tb_nibble_cpu_instruction_execution;
  import nibble_cpu_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clock_in, nrst_in, wdog_clear_in;
  logic div_slow_opt_in, portc_high_opt_in, portd_high_opt_in, wdog_fit_in;
  logic [PC_W-1:0] rom_addr_out;
  logic [7:0] rom_data_in, ctl_out;
  logic [DADDR_W-1:0] ram_addr_out;
  logic [3:0] ram_wdata_out, ram_rdata_in, port_in, port_sel_out;
  logic [3:0] portc_out, portd_out, port_wdata_out, main_operand_reg_out;
  logic ram_we_out, port_we_out, global_irq_enable_out, wdog_irq_out;
  logic carry_flag_out, zero_flag_out;
  logic [4:0] div_ratio_out;
  int mismatches, compares, cycles, i;

  // One straight program; each scenario waits for its checkpoint.
  // A checkpoint with checks follows a one-cycle filler so that all work is done; at 025 the task waits one more cycle instead.
  localparam logic [19:0] PROG [0:39] = '{
    20'h00083, 20'h001C9, 20'h002FE, 20'h003FF, 20'h00481, 20'h005FF,
    20'h007A1, 20'h009C4, 20'h00A72, 20'h00B20, 20'h02032, 20'h02255,
    20'h02354, 20'h02415, 20'h025D4, 20'h02640, 20'h04095, 20'h04150,
    20'h0508C, 20'h05126, 20'h0528D, 20'h05304, 20'h0552C, 20'h05688,
    20'h0582C, 20'h05983, 20'h05A2C, 20'h05B98, 20'h05D6B, 20'h05E45,
    20'h345B5, 20'h01462, 20'h346A9, 20'h34723, 20'h12362, 20'h348C3,
    20'h349C0, 20'h34AC7, 20'h34C6B, 20'h34D4C};

  nibble_cpu_core #(.WDOG_LIMIT(8)) dut_u (
    .clock_in(clock_in), .nrst_in(nrst_in),
    .div_slow_opt_in(div_slow_opt_in),
    .portc_high_opt_in(portc_high_opt_in),
    .portd_high_opt_in(portd_high_opt_in), .wdog_fit_in(wdog_fit_in),
    .rom_addr_out(rom_addr_out), .rom_data_in(rom_data_in),
    .ram_addr_out(ram_addr_out), .ram_wdata_out(ram_wdata_out),
    .ram_we_out(ram_we_out), .ram_rdata_in(ram_rdata_in),
    .port_in(port_in), .port_sel_out(port_sel_out),
    .portc_out(portc_out), .portd_out(portd_out),
    .port_wdata_out(port_wdata_out), .port_we_out(port_we_out),
    .ctl_out(ctl_out), .global_irq_enable_out(global_irq_enable_out),
    .div_ratio_out(div_ratio_out), .wdog_clear_in(wdog_clear_in),
    .wdog_irq_out(wdog_irq_out),
    .main_operand_reg_out(main_operand_reg_out),
    .carry_flag_out(carry_flag_out), .zero_flag_out(zero_flag_out));

  nibble_mem_model mem_u (
    .clock_in(clock_in), .rom_addr_in(rom_addr_out),
    .rom_data_out(rom_data_in), .ram_addr_in(ram_addr_out),
    .ram_wdata_in(ram_wdata_out), .ram_we_in(ram_we_out),
    .ram_rdata_out(ram_rdata_in), .port_sel_in(port_sel_out),
    .portc_in(portc_out), .portd_in(portd_out),
    .port_data_out(port_in));

  // ****************************************************************
  // Closing and helpers
  // ****************************************************************
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A hang in the program stops at the cycle ceiling instead.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic wait_pc(input logic [PC_W-1:0] a);
    int n;
    n = 0;
    @(negedge clock_in);
    while (rom_addr_out !== a && n < 300) begin
      @(negedge clock_in);
      n++;
    end
    `CHECK("fetch address", a, rom_addr_out)
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic check_reset_options;
    @(posedge clock_in);
    @(negedge clock_in);
    `CHECK("div_ratio", DIV_SLOW, div_ratio_out)
    `CHECK("portc", 4'hF, portc_out)
    `CHECK("portd", 4'h0, portd_out)
  endtask

  task automatic check_swaps;
    wait_pc(12'h007);
    `CHECK("operand", 4'h2, main_operand_reg_out)
    `CHECK("zero", 1'h1, zero_flag_out)
    `CHECK("ram001", 4'hA, mem_u.ram[1])
    `CHECK("ram003", 4'h9, mem_u.ram[3])
    `CHECK("ram004", 4'h6, mem_u.ram[4])
    `CHECK("port_sel", 4'h0, port_sel_out)
    wait_pc(12'h009);
    `CHECK("operand", 4'h7, main_operand_reg_out)
    `CHECK("ram000", 4'h2, mem_u.ram[0])
  endtask

  task automatic check_branches;
    wait_pc(12'h020);
    wait_pc(12'h022);
  endtask

  task automatic check_flags;
    wait_pc(12'h025);
    // The clear's second cycle shows this address before it writes back.
    @(negedge clock_in);
    `CHECK("zero", 1'h0, zero_flag_out)
    `CHECK("flag nibble", 4'h1, mem_u.ram[10'h1F3])
    wait_pc(12'h040);
    wait_pc(12'h050);
  endtask

  task automatic check_ports;
    wait_pc(12'h055);
    `CHECK("portc", 4'hB, portc_out)
    `CHECK("portd", 4'h1, portd_out)
  endtask

  task automatic check_control;
    wait_pc(12'h058);
    `CHECK("global enable", 1'h1, global_irq_enable_out)
    wait_pc(12'h05D);
    `CHECK("ctl bit 3", 1'h1, ctl_out[3])
    `CHECK("global enable", 1'h0, global_irq_enable_out)
  endtask

  task automatic check_calls;
    wait_pc(12'h345);
    wait_pc(12'h014);
    wait_pc(12'h346);
    wait_pc(12'h123);
    wait_pc(12'h348);
  endtask

  task automatic check_nop_latch;
    wait_pc(12'h34C);
    `CHECK("operand", 4'h0, main_operand_reg_out)
  endtask

  task automatic check_watchdog;
    int n;
    `CHECK("wdog idle", 1'h0, wdog_irq_out)
    @(posedge clock_in);
    wdog_clear_in <= 1'h0;
    n = 0;
    while (wdog_irq_out !== 1'h1 && n < 40) begin
      @(negedge clock_in);
      n++;
    end
    `CHECK("wdog timeout", 1'h1, wdog_irq_out)
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clock_in = 1'h0;
    forever #2 clock_in = ~clock_in;
  end

  initial begin
    nrst_in = 1'h0;
    div_slow_opt_in = 1'h1;
    portc_high_opt_in = 1'h1;
    portd_high_opt_in = 1'h0;
    wdog_fit_in = 1'h1;
    wdog_clear_in = 1'h1;
    for (i = 0; i < 4096; i++) begin
      mem_u.rom[i] = 8'h00;
    end
    for (i = 0; i < 1024; i++) begin
      mem_u.ram[i] = 4'h0;
    end
    for (i = 0; i < 40; i++) begin
      mem_u.rom[PROG[i][19:8]] = PROG[i][7:0];
    end
    mem_u.ram[0] = 4'h7;
    mem_u.ram[1] = 4'h2;
    mem_u.ram[3] = 4'h6;
    mem_u.ram[4] = 4'hA;
    repeat (4) @(posedge clock_in);
    nrst_in <= 1'h1;
    check_reset_options();
    check_swaps();
    check_branches();
    check_flags();
    check_ports();
    check_control();
    check_calls();
    check_nop_latch();
    check_watchdog();
    report_and_stop();
  end
endmodule
